// ==== pin_mux_map.vh ====
// Constants for the bridge pin multiplexer: modes, widths, reset values
//
// Notes on behaviour
// - Serial clock driven as master, sampled as slave
// - Master-in: single input, bus bit 1, slave output
// - Master-out: single output, bus bit 0, slave input
// - Quad data bits two and three only in quad
// - Shared pin zero: gpio, select one, or I2C clock
// - Shared pin one: gpio, select two, or I2C data
// - Shared pin two: gpio, select three, or suspend
// - Shared pin three: gpio, wakeup input, or interrupt input
// - Select zero output driven whenever SPI master
// - Slave-select input honoured only as SPI slave
// - Master addresses up to four slave channels
// - Master single/dual/quad; slave single full duplex only
// - Active-low chip reset resets the device
// - Test reset active low; held high normally
// - Two strap bits select the chip operating mode
// - Charger detect output with selectable polarity
`ifndef PIN_MUX_MAP_VH
`define PIN_MUX_MAP_VH

// ----------------------------------------------------------------
// Operating modes selected by the two strap bits
// ----------------------------------------------------------------
`define MODE_SPI_MASTER 2'h0
`define MODE_SPI_SLAVE 2'h1
`define MODE_I2C 2'h2
`define MODE_GPIO_ONLY 2'h3

// ----------------------------------------------------------------
// SPI master data widths
// ----------------------------------------------------------------
`define WIDTH_SINGLE 2'h0
`define WIDTH_DUAL 2'h1
`define WIDTH_QUAD 2'h2

// ----------------------------------------------------------------
// Shared pin three functions
// ----------------------------------------------------------------
`define P3_GPIO 2'h0
`define P3_WAKEUP 2'h1
`define P3_INTERRUPT_INPUT 2'h2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MODE_RST 2'h0
`define OE_N_OFF 1'b1
`define PIN_OUT_RST 1'b0
`define SS_OUT_RST 1'b1
// Synchroniser reset: both reset pins held asserted, all other pins idle high
`define SYNC_RST 14'h33ff
`define SYNC_W 14

`endif

// ==== sync_bits.v ====
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module sync_bits #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Data
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta_r;

  always @(posedge mclk) begin
    if (rst) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule // sync_bits

// ==== spi_i2c_bridge_pin_mux.v ====
// Pin function multiplexer for the USB to SPI and I2C bridge
`timescale 1ns/1ps
`include "pin_mux_map.vh"
module spi_i2c_bridge_pin_mux (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Reset and strap pins
  input wire chip_reset_low,
  input wire test_reset_low,
  input wire mode_strap_bit0,
  input wire mode_strap_bit1,
  // Serial clock pin
  input wire sck_in,
  output reg sck_out,
  output reg sck_oe_n,
  // Master-in pin
  input wire miso_in,
  output reg miso_out,
  output reg miso_oe_n,
  // Master-out pin
  input wire mosi_in,
  output reg mosi_out,
  output reg mosi_oe_n,
  // Quad data pins
  input wire quad_data_bit_two_in,
  output reg quad_data_bit_two_out,
  output reg quad_data_bit_two_oe_n,
  input wire quad_data_bit_three_in,
  output reg quad_data_bit_three_out,
  output reg quad_data_bit_three_oe_n,
  // Shared pins
  input wire [3:0] shared_pin_in,
  output reg [3:0] shared_pin_out,
  output reg [3:0] shared_pin_oe_n,
  // Slave select pins
  output reg slave_select_out_0,
  input wire slave_select_in_low,
  // Charger detect pin
  output reg charger_detect_out,
  // Configuration from the core
  input wire [1:0] cfg_width,
  input wire [2:0] cfg_alt_en,
  input wire [1:0] cfg_pin3_func,
  input wire cfg_charger_active_low,
  // SPI engine side
  input wire spi_clk_drive,
  input wire [3:0] spi_dout,
  input wire [3:0] spi_doe,
  input wire [3:0] spi_ss_sel_low,
  output reg [3:0] spi_din,
  output reg spi_sck_sampled,
  output reg spi_slave_selected,
  // I2C engine side
  input wire i2c_scl_drive_low,
  input wire i2c_sda_drive_low,
  output reg i2c_scl_in,
  output reg i2c_sda_in,
  // GPIO and system side
  input wire [3:0] gpio_out,
  input wire [3:0] gpio_dir,
  output reg [3:0] gpio_in,
  input wire usb_suspend,
  output reg remote_wakeup,
  output reg interrupt_input,
  input wire charger_detected,
  // Chip status
  output reg dev_reset,
  output reg [1:0] chip_mode,
  output reg [1:0] active_width
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [`SYNC_W-1:0] raw_pins;
  wire [`SYNC_W-1:0] sync_pins;

  assign raw_pins = {mode_strap_bit1, mode_strap_bit0, test_reset_low,
                     chip_reset_low, slave_select_in_low, shared_pin_in,
                     quad_data_bit_three_in, quad_data_bit_two_in,
                     mosi_in, miso_in, sck_in};

  sync_bits #(
    .WIDTH(`SYNC_W),
    .RST_VAL(`SYNC_RST)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d(raw_pins),
    .q(sync_pins)
  );

  wire sck_s;
  wire miso_s;
  wire mosi_s;
  wire q2_s;
  wire q3_s;
  wire [3:0] shared_s;
  wire ss_in_s;
  wire chip_rst_s;
  wire test_rst_s;
  wire [1:0] strap_s;

  assign sck_s = sync_pins[0];
  assign miso_s = sync_pins[1];
  assign mosi_s = sync_pins[2];
  assign q2_s = sync_pins[3];
  assign q3_s = sync_pins[4];
  assign shared_s = sync_pins[8:5];
  assign ss_in_s = sync_pins[9];
  assign chip_rst_s = sync_pins[10];
  assign test_rst_s = sync_pins[11];
  assign strap_s = sync_pins[13:12];

  // ----------------------------------------------------------------
  // Shared pin selection
  // ----------------------------------------------------------------
  // Returns {out, oe_n}; gpio driver is cut off while alt is set
  function [1:0] pick_pin;
    input alt;
    input alt_out;
    input alt_oe_n;
    input g_out;
    input g_dir;
    begin
      if (alt) begin
        pick_pin = {alt_out, alt_oe_n};
      end else begin
        pick_pin = {g_out, ~g_dir};
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Device reset and strap capture
  // ----------------------------------------------------------------
  wire dev_reset_nxt;

  assign dev_reset_nxt = ~chip_rst_s | ~test_rst_s;

  // Straps follow the pins while held in reset and freeze on release
  always @(posedge mclk) begin
    if (rst) begin
      dev_reset <= 1'b1;
      chip_mode <= `MODE_RST;
    end else begin
      dev_reset <= dev_reset_nxt;
      if (dev_reset) begin
        chip_mode <= strap_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire run;
  wire is_master;
  wire is_slave;
  wire is_i2c;
  reg [1:0] width_nxt;

  assign run = ~dev_reset;
  assign is_master = run & (chip_mode == `MODE_SPI_MASTER);
  assign is_slave = run & (chip_mode == `MODE_SPI_SLAVE);
  assign is_i2c = run & (chip_mode == `MODE_I2C);

  always @* begin
    width_nxt = `WIDTH_SINGLE;
    if (is_master && (cfg_width == `WIDTH_DUAL || cfg_width == `WIDTH_QUAD)) begin
      width_nxt = cfg_width;
    end
  end

  wire wide;
  wire quad;

  assign wide = width_nxt != `WIDTH_SINGLE;
  assign quad = width_nxt == `WIDTH_QUAD;

  // ----------------------------------------------------------------
  // SPI pin next values
  // ----------------------------------------------------------------
  reg sck_out_nxt;
  reg sck_oe_n_nxt;
  reg miso_out_nxt;
  reg miso_oe_n_nxt;
  reg mosi_out_nxt;
  reg mosi_oe_n_nxt;
  reg [1:0] quad_out_nxt;
  reg [1:0] quad_oe_n_nxt;
  reg [3:0] spi_din_nxt;
  reg slave_sel_nxt;

  always @* begin
    sck_out_nxt = `PIN_OUT_RST;
    sck_oe_n_nxt = `OE_N_OFF;
    miso_out_nxt = `PIN_OUT_RST;
    miso_oe_n_nxt = `OE_N_OFF;
    mosi_out_nxt = `PIN_OUT_RST;
    mosi_oe_n_nxt = `OE_N_OFF;
    quad_out_nxt = {2{`PIN_OUT_RST}};
    quad_oe_n_nxt = {2{`OE_N_OFF}};
    spi_din_nxt = 4'h0;
    slave_sel_nxt = 1'b0;
    if (is_master) begin
      sck_out_nxt = spi_clk_drive;
      sck_oe_n_nxt = 1'b0;
      if (wide) begin
        mosi_out_nxt = spi_dout[0];
        mosi_oe_n_nxt = ~spi_doe[0];
        miso_out_nxt = spi_dout[1];
        miso_oe_n_nxt = ~spi_doe[1];
        spi_din_nxt[0] = mosi_s;
        spi_din_nxt[1] = miso_s;
        if (quad) begin
          quad_out_nxt = spi_dout[3:2];
          quad_oe_n_nxt = ~spi_doe[3:2];
          spi_din_nxt[3:2] = {q3_s, q2_s};
        end
      end else begin
        mosi_out_nxt = spi_dout[0];
        mosi_oe_n_nxt = 1'b0;
        spi_din_nxt[0] = miso_s;
      end
    end else if (is_slave) begin
      // Output only while the far master selects this device
      slave_sel_nxt = ~ss_in_s;
      miso_out_nxt = spi_dout[0];
      miso_oe_n_nxt = ss_in_s;
      spi_din_nxt[0] = mosi_s;
    end
  end

  // ----------------------------------------------------------------
  // Shared pin next values
  // ----------------------------------------------------------------
  reg [3:0] sh_out_nxt;
  reg [3:0] sh_oe_n_nxt;
  reg ss0_nxt;
  reg scl_in_nxt;
  reg sda_in_nxt;
  reg wake_nxt;
  reg interrupt_input_nxt;
  reg [1:0] p0;
  reg [1:0] p1;
  reg [1:0] p2;
  reg [1:0] p3;

  always @* begin
    ss0_nxt = `SS_OUT_RST;
    scl_in_nxt = 1'b1;
    sda_in_nxt = 1'b1;
    wake_nxt = 1'b0;
    interrupt_input_nxt = 1'b0;
    if (is_master) begin
      ss0_nxt = spi_ss_sel_low[0];
      p0 = pick_pin(cfg_alt_en[0], spi_ss_sel_low[1], 1'b0,
                    gpio_out[0], gpio_dir[0]);
      p1 = pick_pin(cfg_alt_en[1], spi_ss_sel_low[2], 1'b0,
                    gpio_out[1], gpio_dir[1]);
      p2 = pick_pin(cfg_alt_en[2], spi_ss_sel_low[3], 1'b0,
                    gpio_out[2], gpio_dir[2]);
    end else if (is_i2c) begin
      // Open drain: drive low or release
      p0 = pick_pin(cfg_alt_en[0], 1'b0, ~i2c_scl_drive_low,
                    gpio_out[0], gpio_dir[0]);
      p1 = pick_pin(cfg_alt_en[1], 1'b0, ~i2c_sda_drive_low,
                    gpio_out[1], gpio_dir[1]);
      p2 = pick_pin(cfg_alt_en[2], usb_suspend, 1'b0,
                    gpio_out[2], gpio_dir[2]);
      if (cfg_alt_en[0]) begin
        scl_in_nxt = shared_s[0];
      end
      if (cfg_alt_en[1]) begin
        sda_in_nxt = shared_s[1];
      end
    end else begin
      p0 = pick_pin(1'b0, 1'b0, `OE_N_OFF, gpio_out[0], gpio_dir[0]);
      p1 = pick_pin(1'b0, 1'b0, `OE_N_OFF, gpio_out[1], gpio_dir[1]);
      p2 = pick_pin(cfg_alt_en[2], usb_suspend, 1'b0,
                    gpio_out[2], gpio_dir[2]);
    end
    // Wakeup and interrupt are inputs, so the driver is released
    p3 = pick_pin(cfg_pin3_func != `P3_GPIO, 1'b0, `OE_N_OFF,
                  gpio_out[3], gpio_dir[3]);
    if (run && cfg_pin3_func == `P3_WAKEUP) begin
      wake_nxt = shared_s[3];
    end
    if (run && cfg_pin3_func == `P3_INTERRUPT_INPUT) begin
      interrupt_input_nxt = shared_s[3];
    end
    sh_out_nxt = {p3[1], p2[1], p1[1], p0[1]};
    sh_oe_n_nxt = {p3[0], p2[0], p1[0], p0[0]};
    if (!run) begin
      sh_out_nxt = {4{`PIN_OUT_RST}};
      sh_oe_n_nxt = {4{`OE_N_OFF}};
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      sck_out <= `PIN_OUT_RST;
      sck_oe_n <= `OE_N_OFF;
      miso_out <= `PIN_OUT_RST;
      miso_oe_n <= `OE_N_OFF;
      mosi_out <= `PIN_OUT_RST;
      mosi_oe_n <= `OE_N_OFF;
      quad_data_bit_two_out <= `PIN_OUT_RST;
      quad_data_bit_two_oe_n <= `OE_N_OFF;
      quad_data_bit_three_out <= `PIN_OUT_RST;
      quad_data_bit_three_oe_n <= `OE_N_OFF;
      shared_pin_out <= {4{`PIN_OUT_RST}};
      shared_pin_oe_n <= {4{`OE_N_OFF}};
      slave_select_out_0 <= `SS_OUT_RST;
      charger_detect_out <= 1'b0;
      spi_din <= 4'h0;
      spi_sck_sampled <= 1'b0;
      spi_slave_selected <= 1'b0;
      i2c_scl_in <= 1'b1;
      i2c_sda_in <= 1'b1;
      gpio_in <= 4'h0;
      remote_wakeup <= 1'b0;
      interrupt_input <= 1'b0;
      active_width <= `WIDTH_SINGLE;
    end else begin
      sck_out <= sck_out_nxt;
      sck_oe_n <= sck_oe_n_nxt;
      miso_out <= miso_out_nxt;
      miso_oe_n <= miso_oe_n_nxt;
      mosi_out <= mosi_out_nxt;
      mosi_oe_n <= mosi_oe_n_nxt;
      quad_data_bit_two_out <= quad_out_nxt[0];
      quad_data_bit_two_oe_n <= quad_oe_n_nxt[0];
      quad_data_bit_three_out <= quad_out_nxt[1];
      quad_data_bit_three_oe_n <= quad_oe_n_nxt[1];
      shared_pin_out <= sh_out_nxt;
      shared_pin_oe_n <= sh_oe_n_nxt;
      slave_select_out_0 <= ss0_nxt;
      charger_detect_out <= charger_detected ^ cfg_charger_active_low;
      spi_din <= spi_din_nxt;
      spi_sck_sampled <= is_slave & sck_s;
      spi_slave_selected <= slave_sel_nxt;
      i2c_scl_in <= scl_in_nxt;
      i2c_sda_in <= sda_in_nxt;
      gpio_in <= shared_s;
      remote_wakeup <= wake_nxt;
      interrupt_input <= interrupt_input_nxt;
      active_width <= width_nxt;
    end
  end

endmodule // spi_i2c_bridge_pin_mux

// ==== pin_mux_checker_properties.sv ====
// Concurrent checks on the bridge pin multiplexer ports
`timescale 1ns/1ps
`include "pin_mux_map.vh"
module pin_mux_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Reset pins and status
  input wire logic chip_reset_low,
  input wire logic test_reset_low,
  input wire logic dev_reset,
  input wire logic [1:0] chip_mode,
  input wire logic [1:0] active_width,
  // SPI pins and engine
  input wire logic sck_out,
  input wire logic sck_oe_n,
  input wire logic quad_data_bit_two_oe_n,
  input wire logic quad_data_bit_three_oe_n,
  input wire logic slave_select_out_0,
  input wire logic spi_clk_drive,
  input wire logic [3:0] spi_ss_sel_low,
  input wire logic spi_slave_selected,
  // Charger detect
  input wire logic charger_detect_out,
  input wire logic charger_detected,
  input wire logic cfg_charger_active_low
);
  logic run_r;
  wire run;
  wire mst;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ------------------------------------------------
  // Out of reset for two edges, so pin outputs follow mode
  // ------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      run_r <= 1'b0;
    end else begin
      run_r <= !dev_reset;
    end
  end
  assign run = run_r && !dev_reset;
  assign mst = chip_mode == `MODE_SPI_MASTER;
  // ------------------------------------------------
  // Assertions
  // ------------------------------------------------
  sck_drive_a: assert property (run && mst |-> !sck_oe_n && sck_out == $past(spi_clk_drive))
    else $error("serial clock not driven as master");
  sck_input_a: assert property (run && chip_mode == `MODE_SPI_MASTER + 2'h1 |-> sck_oe_n)
    else $error("serial clock driven as slave");
  sel_zero_a: assert property (run && mst |-> slave_select_out_0 == $past(spi_ss_sel_low[0]))
    else $error("select zero does not follow engine");
  sel_idle_a: assert property (run && !mst |-> slave_select_out_0)
    else $error("select zero active outside master");
  quad_off_a: assert property (run && !mst |-> quad_data_bit_two_oe_n && quad_data_bit_three_oe_n)
    else $error("quad pins driven outside master");
  slave_width_a: assert property (run && !mst |-> active_width == `WIDTH_SINGLE)
    else $error("width not single outside master");
  sel_in_a: assert property (run && chip_mode != `MODE_SPI_SLAVE |-> !spi_slave_selected)
    else $error("select input honoured outside slave");
  charger_a: assert property (run |-> charger_detect_out == $past(charger_detected ^ cfg_charger_active_low))
    else $error("charger output wrong");
  chip_rst_a: assert property (!chip_reset_low |-> ##[1:3] dev_reset)
    else $error("chip reset pin ignored");
  test_rst_a: assert property (!test_reset_low |-> ##[1:3] dev_reset)
    else $error("test reset pin ignored");
  mode_hold_a: assert property (run |-> $stable(chip_mode))
    else $error("mode changed out of reset");
  quad_c: cover property (run && mst && active_width == `WIDTH_QUAD);
  slave_c: cover property (run && spi_slave_selected);
  i2c_c: cover property (run && chip_mode == `MODE_I2C);
endmodule // pin_mux_checker

// ==== far_side_model.sv ====
// Far-side pin model: peripheral drivers, pull-ups and floating lines
`timescale 1ns/1ps
module far_side_model (
  // Clock
  input wire logic mclk,
  // Device side: bits sck, miso, mosi, quad two, quad three, shared 0..3
  input wire logic [8:0] dut_out,
  input wire logic [8:0] dut_oe_n,
  // Far-side drivers
  input wire logic [8:0] far_val,
  input wire logic [8:0] far_en,
  // Resolved pin levels
  output wire logic [8:0] pin
);
  logic [8:0] float_r = 9'h1ff;
  // Undriven data lines flip every cycle; shared pins rest on pull-ups
  always @(posedge mclk) begin
    float_r <= {4'hf, ~float_r[4:0]};
  end
  assign pin = (~dut_oe_n & dut_out) | (dut_oe_n & far_en & far_val)
    | (dut_oe_n & ~far_en & float_r);
endmodule // far_side_model

// ==== spi_i2c_bridge_pin_mux_tb_top.sv ====
// Testbench for the bridge pin multiplexer
`timescale 1ns/1ps
`include "pin_mux_map.vh"
module spi_i2c_bridge_pin_mux_tb_top;
  // ------------------------------------------------
  // Signals
  // ------------------------------------------------
  logic mclk, rst, chip_reset_low, test_reset_low, mode_strap_bit0, mode_strap_bit1;
  logic slave_select_in_low, cfg_charger_active_low, spi_clk_drive, usb_suspend;
  logic i2c_scl_drive_low, i2c_sda_drive_low, charger_detected;
  logic [1:0] cfg_width, cfg_pin3_func;
  logic [2:0] cfg_alt_en;
  logic [3:0] spi_dout, spi_doe, spi_ss_sel_low, gpio_out, gpio_dir;
  logic [8:0] far_val, far_en;
  wire [8:0] pin;
  wire sck_in, miso_in, mosi_in, quad_data_bit_two_in, quad_data_bit_three_in;
  wire sck_out, sck_oe_n, miso_out, miso_oe_n, mosi_out, mosi_oe_n, slave_select_out_0;
  wire quad_data_bit_two_out, quad_data_bit_two_oe_n, quad_data_bit_three_out;
  wire quad_data_bit_three_oe_n, charger_detect_out, spi_sck_sampled, spi_slave_selected;
  wire i2c_scl_in, i2c_sda_in, remote_wakeup, interrupt_input, dev_reset;
  wire [3:0] shared_pin_in, shared_pin_out, shared_pin_oe_n, spi_din, gpio_in;
  wire [1:0] chip_mode, active_width;
  integer error_cnt = 0, n_checks = 0, cyc = 0;
  assign {shared_pin_in, quad_data_bit_three_in, quad_data_bit_two_in, mosi_in, miso_in,
    sck_in} = pin;
  spi_i2c_bridge_pin_mux u_dut (.*);
  far_side_model u_far (
    .mclk(mclk),
    .dut_out({shared_pin_out, quad_data_bit_three_out, quad_data_bit_two_out, mosi_out,
      miso_out, sck_out}),
    .dut_oe_n({shared_pin_oe_n, quad_data_bit_three_oe_n, quad_data_bit_two_oe_n,
      mosi_oe_n, miso_oe_n, sck_oe_n}),
    .far_val(far_val),
    .far_en(far_en),
    .pin(pin)
  );
  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      finish_test;
    end
  end
  task finish_test;
    begin
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [3:0] got, input logic [3:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task w(input integer n);
    repeat (n) @(negedge mclk);
  endtask
  task set_mode(input logic [1:0] m);
    integer i;
    begin
      chip_reset_low = 1'b0;
      {mode_strap_bit1, mode_strap_bit0} = m;
      w(4);
      chk("dev_reset", dev_reset, 4'h1);
      chip_reset_low = 1'b1;
      for (i = 0; i < 8 && dev_reset !== 1'b0; i++) w(1);
      w(1);
      chk("chip_mode", chip_mode, m);
    end
  endtask
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task t_master;
    begin
      spi_clk_drive = 1'b1;
      spi_dout = 4'h1;
      spi_doe = 4'h1;
      spi_ss_sel_low = 4'he;
      far_en = 9'h002;
      far_val = 9'h002;
      w(1);
      chk("sck", {sck_oe_n, sck_out}, 4'h1);
      chk("mosi", {mosi_oe_n, mosi_out}, 4'h1);
      chk("miso_oe_n", miso_oe_n, 4'h1);
      chk("quad_oe_n", {quad_data_bit_three_oe_n, quad_data_bit_two_oe_n}, 4'h3);
      chk("ss0", slave_select_out_0, 4'h0);
      w(2);
      chk("din0", spi_din[0], 4'h1);
      cfg_width = `WIDTH_QUAD;
      spi_doe = 4'hf;
      spi_dout = 4'ha;
      far_en = 9'h000;
      w(1);
      chk("quad_out", {quad_data_bit_three_out, quad_data_bit_two_out, miso_out, mosi_out},
        4'ha);
      chk("quad_oe", {quad_data_bit_three_oe_n, quad_data_bit_two_oe_n, miso_oe_n, mosi_oe_n},
        4'h0);
      w(3);
      chk("quad_din", spi_din, 4'ha);
      cfg_width = `WIDTH_DUAL;
      cfg_alt_en = 3'h7;
      gpio_dir = 4'hf;
      gpio_out = 4'hf;
      spi_ss_sel_low = 4'h5;
      w(1);
      chk("dual_quad_oe", {quad_data_bit_three_oe_n, quad_data_bit_two_oe_n}, 4'h3);
      chk("width", active_width, `WIDTH_DUAL);
      chk("sel_out", shared_pin_out, 4'ha);
      chk("sel_oe", shared_pin_oe_n, 4'h0);
    end
  endtask
  task t_slave;
    begin
      cfg_width = `WIDTH_QUAD;
      spi_doe = 4'h1;
      spi_dout = 4'h1;
      far_en = 9'h005;
      far_val = 9'h005;
      w(3);
      chk("slave_sck_oe", sck_oe_n, 4'h1);
      chk("slave_sck_in", spi_sck_sampled, 4'h1);
      chk("slave_width", active_width, `WIDTH_SINGLE);
      chk("slave_idle", {spi_slave_selected, miso_oe_n, slave_select_out_0}, 4'h3);
      slave_select_in_low = 1'b0;
      w(3);
      chk("slave_sel", {spi_slave_selected, miso_oe_n, miso_out}, 4'h5);
      chk("slave_din", spi_din[0], 4'h1);
      slave_select_in_low = 1'b1;
    end
  endtask
  task t_i2c;
    begin
      cfg_alt_en = 3'h7;
      slave_select_in_low = 1'b0;
      usb_suspend = 1'b1;
      i2c_scl_drive_low = 1'b1;
      far_en = 9'h000;
      w(1);
      chk("i2c_oe", shared_pin_oe_n[2:0], 4'h2);
      chk("i2c_out", shared_pin_out[2:0], 4'h4);
      w(2);
      chk("sda_pull", i2c_sda_in, 4'h1);
      far_en = 9'h040;
      far_val = 9'h000;
      w(3);
      chk("sda_low", i2c_sda_in, 4'h0);
      chk("scl_low", i2c_scl_in, 4'h0);
      chk("i2c_no_sel", spi_slave_selected, 4'h0);
      slave_select_in_low = 1'b1;
      i2c_scl_drive_low = 1'b0;
    end
  endtask
  task t_misc;
    begin
      cfg_alt_en = 3'h0;
      gpio_dir = 4'hf;
      gpio_out = 4'h5;
      cfg_charger_active_low = 1'b1;
      w(1);
      chk("gpio_out", shared_pin_out, 4'h5);
      chk("gpio_oe", shared_pin_oe_n, 4'h0);
      chk("charger_inv", charger_detect_out, 4'h1);
      charger_detected = 1'b1;
      cfg_charger_active_low = 1'b0;
      gpio_dir = 4'h0;
      cfg_pin3_func = `P3_WAKEUP;
      far_en = 9'h100;
      far_val = 9'h100;
      w(4);
      chk("charger", charger_detect_out, 4'h1);
      chk("wakeup", {shared_pin_oe_n[3], remote_wakeup}, 4'h3);
      cfg_pin3_func = `P3_INTERRUPT_INPUT;
      w(3);
      chk("interrupt_input", interrupt_input, 4'h1);
      chk("gpio_in", gpio_in, 4'hf);
      test_reset_low = 1'b0;
      w(4);
      chk("test_reset", dev_reset, 4'h1);
      test_reset_low = 1'b1;
      w(6);
      chk("test_release", dev_reset, 4'h0);
    end
  endtask
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    {rst, chip_reset_low, test_reset_low, slave_select_in_low} = 4'hf;
    {mode_strap_bit0, mode_strap_bit1, cfg_charger_active_low, spi_clk_drive} = 4'h0;
    {usb_suspend, i2c_scl_drive_low, i2c_sda_drive_low, charger_detected} = 4'h0;
    {cfg_width, cfg_pin3_func, cfg_alt_en} = 7'h00;
    {spi_dout, spi_doe, spi_ss_sel_low, gpio_out, gpio_dir} = 20'h00f00;
    far_val = 9'h000;
    far_en = 9'h000;
    w(6);
    rst = 1'b0;
    set_mode(`MODE_SPI_MASTER);
    t_master;
    set_mode(`MODE_SPI_SLAVE);
    t_slave;
    set_mode(`MODE_I2C);
    t_i2c;
    set_mode(`MODE_GPIO_ONLY);
    t_misc;
    finish_test;
  end
endmodule // spi_i2c_bridge_pin_mux_tb_top
bind spi_i2c_bridge_pin_mux pin_mux_checker u_chk (.mclk, .rst, .chip_reset_low,
  .test_reset_low, .dev_reset, .chip_mode, .active_width, .sck_out, .sck_oe_n,
  .quad_data_bit_two_oe_n, .quad_data_bit_three_oe_n, .slave_select_out_0, .spi_clk_drive,
  .spi_ss_sel_low, .spi_slave_selected, .charger_detect_out, .charger_detected,
  .cfg_charger_active_low);
